// File: core/flags_consts.svh
// Constants for the processor flags block: bit positions, reset value, limits
// ============================================================================
// Behaviour
// - Decimal mode sits at bit 3, break at bit 4, index mode at bit 5, overflow at bit 6 and negative at bit 7 of the flags byte.
// - Add and subtract run in binary when decimal mode is 0 and in decimal with automatic correction when it is 1.
// - Only add-with-carry and subtract-with-borrow use decimal arithmetic; all other operations ignore decimal mode.
// - The live break flag always reads 0, and the pushed flags byte carries break as 1 only for the break trap.
// - Index mode 0 works between accumulator and memory; index mode 1 works directly between memory locations.
// - Overflow is set when a signed byte add or subtract leaves the range -128 to +127.
// - The memory-test operation copies memory bit 6 into overflow.
// - Negative is set for a negative arithmetic or transfer result and cleared otherwise.
// - The memory-test operation copies memory bit 7 into negative.
// - Carry, interrupt mask, decimal and index mode have set and clear operations, overflow only a clear, and zero, break and negative none.
// - Carry holds the carry or borrow of the last arithmetic operation and shifts and rotates may change it.
// - Zero is set for a zero arithmetic or transfer result and cleared for any other.
// - While the interrupt mask is 1 every interrupt except the break trap is blocked.
// - After decimal arithmetic the zero, overflow and negative values carry no meaning.
`ifndef FLAGS_CONSTS_SVH
`define FLAGS_CONSTS_SVH

`define FLG_C          3'd0
`define FLG_Z          3'd1
`define FLG_I          3'd2
`define FLG_D          3'd3
`define FLG_B          3'd4
`define FLG_T          3'd5
`define FLG_V          3'd6
`define FLG_N          3'd7
`define FLAGS_RESET    8'h04
`define BYTE_ZERO      8'h00
`define BCD_LIMIT      5'h09
`define BCD_ADJ        5'h06
`define BCD_WRAP       5'h0a
`define NIB_MASK       4'hf

`endif

// File: core/flags_pkg.sv
// Types shared by the processor flags block
package flags_pkg;
    typedef enum logic [3:0] {
        OP_NONE,
        OP_ADD,
        OP_SUB,
        OP_TRANSFER,
        OP_SHIFT,
        OP_MEM_TEST,
        OP_BREAK,
        OP_FLAG_SET,
        OP_FLAG_CLR,
        OP_FLAGS_LOAD
    } flag_op_t;

    typedef enum logic [2:0] {
        SEL_CARRY,
        SEL_IRQ_MASK,
        SEL_DECIMAL,
        SEL_INDEX,
        SEL_OVERFLOW
    } flag_sel_t;
endpackage

// File: core/flags_adder.sv
// Byte adder and subtractor with binary and decimal modes
`timescale 1ns/1ps
`default_nettype none
`include "flags_consts.svh"
module flags_adder (
    // Operands
    input  wire logic [7:0] i_a,
    input  wire logic [7:0] i_b,
    input  wire logic       i_carry,
    // Mode
    input  wire logic       i_sub,
    input  wire logic       i_decimal,
    // Result
    output logic      [7:0] o_sum,
    output logic            o_carry,
    output logic            o_overflow
);
    logic [7:0] b_eff;
    logic [8:0] bin_sum;
    logic [4:0] lo;
    logic [4:0] hi;
    logic       lo_c;
    logic       hi_c;

    // Subtract adds the one's complement so carry acts as not-borrow
    assign b_eff   = i_sub ? ~i_b : i_b;
    assign bin_sum = {1'b0, i_a} + {1'b0, b_eff} + {8'h00, i_carry};

    // Decimal correction on each nibble
    always_comb begin
        lo   = {1'b0, i_a[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, i_carry};
        lo_c = 1'b0;
        if (!i_sub && lo > `BCD_LIMIT) begin
            lo   = lo + `BCD_ADJ;
            lo_c = 1'b1;
        end else if (i_sub) begin
            lo_c = lo[4];
            if (!lo[4]) lo = lo - `BCD_ADJ;
        end else begin
            lo_c = lo[4];
        end
        hi   = {1'b0, i_a[7:4]} + {1'b0, b_eff[7:4]} + {4'h0, lo_c};
        hi_c = 1'b0;
        if (!i_sub && hi > `BCD_LIMIT) begin
            hi   = hi + `BCD_ADJ;
            hi_c = 1'b1;
        end else if (i_sub) begin
            hi_c = hi[4];
            if (!hi[4]) hi = hi - `BCD_ADJ;
        end else begin
            hi_c = hi[4];
        end
    end

    // Select binary or corrected decimal result
    always_comb begin
        if (i_decimal) begin
            o_sum   = {hi[3:0], lo[3:0]};
            o_carry = hi_c;
        end else begin
            o_sum   = bin_sum[7:0];
            o_carry = bin_sum[8];
        end
    end

    // Signed range exceeded when operands agree in sign and result differs
    assign o_overflow = (i_a[7] == b_eff[7]) && (bin_sum[7] != i_a[7]);
endmodule // flags_adder
`default_nettype wire

// File: core/cpu_status_flags.sv
// Processor flags register with its arithmetic and update logic
`timescale 1ns/1ps
`default_nettype none
`include "flags_consts.svh"
module cpu_status_flags (
    // Clock and reset
    input  wire logic               i_ref_clk,
    input  wire logic               i_rst,
    // Operation request
    input  wire logic               i_op_valid,
    input  wire flags_pkg::flag_op_t  i_op,
    input  wire flags_pkg::flag_sel_t i_sel,
    input  wire logic [7:0]         i_acc,
    input  wire logic [7:0]         i_mem,
    input  wire logic [7:0]         i_mem_dst,
    input  wire logic [7:0]         i_result,
    input  wire logic               i_shift_carry,
    input  wire logic [7:0]         i_flags_in,
    // Interrupt request
    input  wire logic               i_irq_req,
    // Results
    output logic      [7:0]         o_flags,
    output logic      [7:0]         o_push_flags,
    output logic      [7:0]         o_alu_result,
    output logic                    o_result_to_mem,
    output logic                    o_irq_take
);
    import flags_pkg::*;

    // ========================================================================
    // Arithmetic
    logic [7:0] flags_r;
    logic [7:0] flags_nxt;
    logic [7:0] lhs;
    logic [7:0] sum;
    logic       sum_c;
    logic       sum_v;
    logic       is_arith;
    logic       dec_en;

    // Index mode picks the left operand
    assign lhs      = flags_r[`FLG_T] ? i_mem_dst : i_acc;
    assign is_arith = (i_op == OP_ADD) || (i_op == OP_SUB);
    assign dec_en   = is_arith && flags_r[`FLG_D];

    flags_adder u_adder (
        .i_a        (lhs),
        .i_b        (i_mem),
        .i_carry    (flags_r[`FLG_C]),
        .i_sub      (i_op == OP_SUB),
        .i_decimal  (dec_en),
        .o_sum      (sum),
        .o_carry    (sum_c),
        .o_overflow (sum_v)
    );

    // Zero and negative from a result byte
    function automatic logic [1:0] zn(input logic [7:0] v);
        zn = {v[7], v == `BYTE_ZERO};
    endfunction

    // ========================================================================
    // Flag update
    always_comb begin
        flags_nxt = flags_r;
        if (i_op_valid) begin
            unique case (i_op)
                OP_ADD, OP_SUB: begin
                    flags_nxt[`FLG_C] = sum_c;
                    flags_nxt[`FLG_V] = sum_v;
                    {flags_nxt[`FLG_N], flags_nxt[`FLG_Z]} = zn(sum);
                end
                OP_TRANSFER: begin
                    {flags_nxt[`FLG_N], flags_nxt[`FLG_Z]} = zn(i_result);
                end
                OP_SHIFT: begin
                    flags_nxt[`FLG_C] = i_shift_carry;
                    {flags_nxt[`FLG_N], flags_nxt[`FLG_Z]} = zn(i_result);
                end
                OP_MEM_TEST: begin
                    flags_nxt[`FLG_V] = i_mem[6];
                    flags_nxt[`FLG_N] = i_mem[7];
                    flags_nxt[`FLG_Z] = ((i_acc & i_mem) == `BYTE_ZERO);
                end
                OP_BREAK: begin
                    flags_nxt[`FLG_I] = 1'b1;
                end
                OP_FLAG_SET: begin
                    unique case (i_sel)
                        SEL_CARRY:    flags_nxt[`FLG_C] = 1'b1;
                        SEL_IRQ_MASK: flags_nxt[`FLG_I] = 1'b1;
                        SEL_DECIMAL:  flags_nxt[`FLG_D] = 1'b1;
                        SEL_INDEX:    flags_nxt[`FLG_T] = 1'b1;
                        default:      flags_nxt = flags_r; // No overflow set
                    endcase
                end
                OP_FLAG_CLR: begin
                    unique case (i_sel)
                        SEL_CARRY:    flags_nxt[`FLG_C] = 1'b0;
                        SEL_IRQ_MASK: flags_nxt[`FLG_I] = 1'b0;
                        SEL_DECIMAL:  flags_nxt[`FLG_D] = 1'b0;
                        SEL_INDEX:    flags_nxt[`FLG_T] = 1'b0;
                        SEL_OVERFLOW: flags_nxt[`FLG_V] = 1'b0;
                        default:      flags_nxt = flags_r;
                    endcase
                end
                OP_FLAGS_LOAD: begin
                    flags_nxt = i_flags_in;
                end
                default: flags_nxt = flags_r;
            endcase
        end
        flags_nxt[`FLG_B] = 1'b0;
    end

    // Flags register
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) flags_r <= `FLAGS_RESET;
        else       flags_r <= flags_nxt;
    end

    // ========================================================================
    // Registered outputs
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            o_flags      <= `FLAGS_RESET;
            o_push_flags <= `FLAGS_RESET;
        end else begin
            o_flags      <= flags_nxt;
            o_push_flags <= flags_r;
            // Break trap pushes the flags with break marked
            if (i_op_valid && i_op == OP_BREAK)
                o_push_flags[`FLG_B] <= 1'b1;
            else
                o_push_flags[`FLG_B] <= 1'b0;
        end
    end

    // Arithmetic result and its destination
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            o_alu_result    <= `BYTE_ZERO;
            o_result_to_mem <= 1'b0;
        end else if (i_op_valid && is_arith) begin
            o_alu_result    <= sum;
            o_result_to_mem <= flags_r[`FLG_T];
        end
    end

    // Interrupt gate: break always passes, others only while unmasked
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) o_irq_take <= 1'b0;
        else       o_irq_take <= (i_op_valid && i_op == OP_BREAK)
                                 || (i_irq_req && !flags_r[`FLG_I]);
    end
endmodule // cpu_status_flags
`default_nettype wire

// File: bench/cpu_status_flags_monitor.sv
// Checker for the processor flags block
`timescale 1ns/1ps
`default_nettype none
module cpu_status_flags_monitor
    import flags_pkg::*;
(
    // Clock, reset and operation inputs
    input wire logic       i_ref_clk, i_rst, i_op_valid, i_shift_carry, i_irq_req,
    input wire flag_op_t   i_op,
    input wire flag_sel_t  i_sel,
    input wire logic [7:0] i_acc, i_mem, i_mem_dst, i_result, i_flags_in,
    // Design outputs
    input wire logic [7:0] o_flags, o_push_flags, o_alu_result,
    input wire logic       o_result_to_mem, o_irq_take
);
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_rst);
    // True when the given operation is taken this cycle
    function automatic logic took(flag_op_t k);
        return i_op_valid && i_op == k;
    endfunction
    brk_live_a: assert property (!o_flags[4])
        else $error("break bit seen in live flags");
    push_brk_a: assert property (took(OP_BREAK) |=> o_push_flags[4] && o_irq_take)
        else $error("break trap not pushed or taken");
    push_plain_a: assert property (!took(OP_BREAK) |=> !o_push_flags[4])
        else $error("break bit pushed without trap");
    mem_test_a: assert property (took(OP_MEM_TEST) |=> o_flags[7:6] == $past(i_mem[7:6]))
        else $error("memory test bits not copied");
    xfer_nz_a: assert property (took(OP_TRANSFER) |=> o_flags[7] == $past(i_result[7])
        && o_flags[1] == ($past(i_result) == 8'h00)) else $error("transfer sign or zero wrong");
    ovf_keep_a: assert property (took(OP_FLAG_SET) && i_sel == SEL_OVERFLOW |=> $stable(o_flags))
        else $error("overflow set changed flags");
    carry_set_a: assert property (took(OP_FLAG_SET) && i_sel == SEL_CARRY |=> o_flags[0])
        else $error("carry set failed");
    irq_mask_a: assert property (i_irq_req && o_flags[2] && !i_op_valid |=> !o_irq_take)
        else $error("masked interrupt taken");
    bin_add_a: assert property (took(OP_ADD) && !o_flags[3] && !o_flags[5] |=>
        {o_flags[0], o_alu_result} == $past({1'b0, i_acc} + {1'b0, i_mem} + {8'h00, o_flags[0]}))
        else $error("binary add wrong");
    index_a: assert property ((took(OP_ADD) || took(OP_SUB)) && o_flags[5] |=> o_result_to_mem)
        else $error("index mode result not routed to memory");
    cover property (took(OP_BREAK));
    cover property (took(OP_ADD) && o_flags[3]);
    cover property (took(OP_MEM_TEST));
endmodule // cpu_status_flags_monitor
bind cpu_status_flags cpu_status_flags_monitor cpu_status_flags_monitor_inst (
    .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_op_valid(i_op_valid), .i_op(i_op), .i_sel(i_sel),
    .i_acc(i_acc), .i_mem(i_mem), .i_mem_dst(i_mem_dst), .i_result(i_result),
    .i_shift_carry(i_shift_carry), .i_flags_in(i_flags_in), .i_irq_req(i_irq_req),
    .o_flags(o_flags), .o_push_flags(o_push_flags), .o_alu_result(o_alu_result),
    .o_result_to_mem(o_result_to_mem), .o_irq_take(o_irq_take));
`default_nettype wire

// File: bench/cpu_status_flags_test.sv
// Self-checking bench for the processor flags block
`timescale 1ns/1ps
`default_nettype none
module cpu_status_flags_test;
    import flags_pkg::*;
    logic       i_ref_clk = 1'b0, i_rst = 1'b1, i_op_valid = 1'b0;
    logic       i_shift_carry = 1'b0, i_irq_req = 1'b0;
    flag_op_t   i_op = OP_NONE;
    flag_sel_t  i_sel = SEL_CARRY;
    logic [7:0] i_acc = 8'h00, i_mem = 8'h00, i_mem_dst = 8'h00;
    logic [7:0] i_result = 8'h00, i_flags_in = 8'h00;
    logic [7:0] o_flags, o_push_flags, o_alu_result;
    logic       o_result_to_mem, o_irq_take;
    int         err_count = 0, checks = 0;
    // 100 MHz clock
    always #5 i_ref_clk = ~i_ref_clk;
    cpu_status_flags cpu_status_flags_inst (
        .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_op_valid(i_op_valid), .i_op(i_op), .i_sel(i_sel),
        .i_acc(i_acc), .i_mem(i_mem), .i_mem_dst(i_mem_dst), .i_result(i_result),
        .i_shift_carry(i_shift_carry), .i_flags_in(i_flags_in), .i_irq_req(i_irq_req),
        .o_flags(o_flags), .o_push_flags(o_push_flags), .o_alu_result(o_alu_result),
        .o_result_to_mem(o_result_to_mem), .o_irq_take(o_irq_take));
    // Compare one byte result
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Issue one operation for one cycle, return where its results are settled
    task automatic run(input flag_op_t op, input logic [7:0] a, m,
                       input flag_sel_t s = SEL_CARRY, input logic [7:0] d = 8'h00);
        @(negedge i_ref_clk);
        i_op_valid = 1'b1;
        i_op = op;
        i_sel = s;
        i_acc = a;
        i_mem = m;
        i_result = m;
        i_flags_in = m;
        i_mem_dst = d;
        @(negedge i_ref_clk);
        i_op_valid = 1'b0;
    endtask
    task automatic ld(input logic [7:0] v);
        run(OP_FLAGS_LOAD, 8'h00, v);
    endtask
    task automatic t_reset;
        chk(o_flags, 8'h04);
        chk(o_push_flags, 8'h04);
        chk({7'h0, o_irq_take}, 8'h00);
    endtask
    // Binary add and subtract, one idle cycle apart, with signed overflow edges
    task automatic t_arith;
        ld(8'h00);
        run(OP_ADD, 8'h7f, 8'h01);
        chk(o_alu_result, 8'h80);
        chk(o_flags, 8'hc0);
        run(OP_ADD, 8'hff, 8'h01);
        chk(o_flags, 8'h03);
        run(OP_SUB, 8'h00, 8'h01);
        chk(o_alu_result, 8'hff);
        chk(o_flags, 8'h80);
        run(OP_SUB, 8'h80, 8'h01);
        chk(o_alu_result, 8'h7e);
        chk(o_flags, 8'h41);
    endtask
    // Decimal correction on add and subtract; shift ignores decimal mode
    task automatic t_decimal;
        ld(8'h08);
        run(OP_ADD, 8'h19, 8'h01);
        chk(o_alu_result, 8'h20);
        chk(o_flags & 8'h0d, 8'h08);
        run(OP_FLAG_SET, 8'h00, 8'h00, SEL_CARRY);
        run(OP_SUB, 8'h20, 8'h01);
        chk(o_alu_result, 8'h19);
        chk(o_flags & 8'h0d, 8'h09);
        i_shift_carry = 1'b1;
        run(OP_SHIFT, 8'h00, 8'h0a);
        chk(o_flags & 8'hbf, 8'h09);
        i_shift_carry = 1'b0;
    endtask
    // Raise and drop of each flag that has them; overflow has a drop only
    task automatic t_flag_ops;
        flag_sel_t  sel_tab [4] = '{SEL_CARRY, SEL_IRQ_MASK, SEL_DECIMAL, SEL_INDEX};
        logic [7:0] bit_tab [4] = '{8'h01, 8'h04, 8'h08, 8'h20};
        ld(8'h40);
        foreach (sel_tab[k]) begin
            run(OP_FLAG_SET, 8'h00, 8'h00, sel_tab[k]);
            chk(o_flags, 8'h40 | bit_tab[k]);
            run(OP_FLAG_CLR, 8'h00, 8'h00, sel_tab[k]);
            chk(o_flags, 8'h40);
        end
        run(OP_FLAG_SET, 8'h00, 8'h00, SEL_OVERFLOW);
        chk(o_flags, 8'h40);
        run(OP_FLAG_CLR, 8'h00, 8'h00, SEL_OVERFLOW);
        chk(o_flags, 8'h00);
    endtask
    // Break trap pushes break as one, live break stays zero
    task automatic t_break;
        ld(8'hff);
        chk(o_flags, 8'hef);
        ld(8'h00);
        run(OP_BREAK, 8'h00, 8'h00);
        chk(o_push_flags, 8'h10);
        chk(o_flags, 8'h04);
        chk({7'h0, o_irq_take}, 8'h01);
        @(negedge i_ref_clk);
        chk(o_push_flags, 8'h04);
        chk({7'h0, o_irq_take}, 8'h00);
    endtask
    // Interrupt passes with mask off, blocked with mask on
    task automatic t_irq;
        ld(8'h00);
        i_irq_req = 1'b1;
        @(negedge i_ref_clk);
        chk({7'h0, o_irq_take}, 8'h01);
        run(OP_FLAG_SET, 8'h00, 8'h00, SEL_IRQ_MASK);
        @(negedge i_ref_clk);
        chk({7'h0, o_irq_take}, 8'h00);
        i_irq_req = 1'b0;
    endtask
    // Memory test copies bits 7 and 6; transfers set sign and zero
    task automatic t_bits;
        ld(8'h00);
        run(OP_MEM_TEST, 8'h3f, 8'hc0);
        chk(o_flags, 8'hc2);
        run(OP_MEM_TEST, 8'h01, 8'h01);
        chk(o_flags, 8'h00);
        run(OP_TRANSFER, 8'h00, 8'h00);
        chk(o_flags, 8'h02);
        run(OP_TRANSFER, 8'h00, 8'h9c);
        chk(o_flags, 8'h80);
    endtask
    // Index mode takes the memory destination as left operand
    task automatic t_index;
        ld(8'h20);
        run(OP_ADD, 8'hff, 8'h05, SEL_CARRY, 8'h10);
        chk(o_alu_result, 8'h15);
        chk({7'h0, o_result_to_mem}, 8'h01);
        ld(8'h00);
        run(OP_ADD, 8'h01, 8'h05, SEL_CARRY, 8'h10);
        chk(o_alu_result, 8'h06);
        chk({7'h0, o_result_to_mem}, 8'h00);
    endtask
    task automatic print_verdict;
        $display("Comparisons %0d, mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // Watchdog: the tests need about 85 cycles, allow 500
    initial begin
        #5000;
        err_count++;
        print_verdict();
    end
    initial begin
        repeat (10) @(negedge i_ref_clk);
        i_rst = 1'b0;
        t_reset();
        t_arith();
        t_decimal();
        t_flag_ops();
        t_break();
        t_irq();
        t_bits();
        t_index();
        print_verdict();
    end
endmodule // cpu_status_flags_test
`default_nettype wire
